// ==== hdl/dlc_data_link.sv ====
`include "dlc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module dlc_data_link #(
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // Host parallel port
   input  wire dlc_pkg::dlc_host_req_t host_req,
   output logic [7:0]                  host_rdata,
   // Control bits held outside this block; flags and interrupt driven from it
   input  wire logic                   zero_destuff_enable,
   input  wire logic                   legacy_byte_full_mask,
   input  wire logic                   legacy_match_mask,
   output logic                        legacy_byte_full_flag,
   output logic                        legacy_match_flag,
   output logic                        code_change_flag,
   input  wire logic                   legacy_flag_clear,
   output logic                        int_n,
   // Code detector and packet receiver
   input  wire logic                   code_present_now,
   input  wire logic [5:0]             detected_code,
   input  wire logic                   rx_pkt_valid,
   input  wire logic [7:0]             rx_pkt_data,
   output logic                        rx_pkt_ready,
   // Legacy receive bit stream
   input  wire logic                   legacy_bit_strobe,
   input  wire logic                   legacy_bit,
   // Transmit link
   input  wire logic                   tx_bit_strobe,
   input  wire logic                   external_link_data_in,
   input  wire logic                   tx_msg_active,
   output logic                        tx_link_bit
);
   localparam int AW = $clog2(DEPTH);
   // Host strobes and flag clears
   logic rd_rxc, rd_rxf, rd_txs, wr_txc, wr_txf;
   function automatic logic hit(input logic s, input logic [7:0] a, input logic [7:0] off);
      hit = s && (a == off);
   endfunction
   assign rd_rxc = hit(host_req.rd, host_req.addr, `DLC_ADDR_RX_CODE);
   assign rd_rxf = hit(host_req.rd, host_req.addr, `DLC_ADDR_RX_FIFO);
   assign rd_txs = hit(host_req.rd, host_req.addr, `DLC_ADDR_TX_STATUS);
   assign wr_txc = hit(host_req.wr, host_req.addr, `DLC_ADDR_TX_CODE);
   assign wr_txf = hit(host_req.wr, host_req.addr, `DLC_ADDR_TX_FIFO);
   // Receive packet path through the two-entry buffer
   logic       rxb_valid;
   logic [7:0] rxb_data;
   dlc_skid_buffer #(.WIDTH(8)) u_rx_buf (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .in_valid (rx_pkt_valid),
      .in_data  (rx_pkt_data),
      .in_ready (rx_pkt_ready),
      .out_valid(rxb_valid),
      .out_data (rxb_data),
      .out_ready(rd_rxf)
   );
   // Register state
   logic [5:0] rx_code, tx_code, next_rx_code, next_tx_code;
   logic       code_seen_latched, code_prev, send_code_trigger, link_source_select;
   logic       tx_underrun_flag, next_code_seen_latched, next_code_change_flag;
   logic       next_send_code_trigger, next_link_source_select, next_tx_underrun_flag;
   logic [7:0] legacy_rx_byte, legacy_shift, legacy_match_byte_a, legacy_match_byte_b;
   logic [7:0] next_host_rdata, next_legacy_rx_byte, next_legacy_shift;
   logic [7:0] next_match_a, next_match_b;
   logic [2:0] legacy_cnt, ones_run, next_legacy_cnt, next_ones_run;
   logic       next_byte_full, next_match;
   // Transmit FIFO and serializer state
   logic [7:0]             txq [0:DEPTH-1];
   logic [AW-1:0]          wr_ptr, rd_ptr;
   logic [AW:0]            txq_count;
   logic                   tx_queue_empty, tx_queue_full, tx_bit, next_tx_bit, pop, push;
   dlc_pkg::dlc_tx_state_t tx_state, next_tx_state;
   logic [7:0]             tx_shift, next_tx_shift;
   logic [2:0]             tx_bitcnt, next_tx_bitcnt;
   // Queue flags
   assign tx_queue_empty = (txq_count == '0);
   assign tx_queue_full  = (txq_count == (AW+1)'(DEPTH));
   assign push           = wr_txf && !tx_queue_full;
   always_comb begin
      logic       code_edge;
      logic       byte_done;
      logic [7:0] shifted;
      code_edge              = code_present_now ^ code_prev;
      byte_done              = 1'b0;
      shifted                = legacy_shift;
      next_rx_code           = rx_code;
      next_code_seen_latched = code_seen_latched;
      next_code_change_flag  = code_change_flag;
      next_send_code_trigger = send_code_trigger;
      next_link_source_select = link_source_select;
      next_tx_code           = tx_code;
      next_legacy_rx_byte    = legacy_rx_byte;
      next_legacy_shift      = legacy_shift;
      next_legacy_cnt        = legacy_cnt;
      next_ones_run          = ones_run;
      next_byte_full         = legacy_byte_full_flag;
      next_match             = legacy_match_flag;
      next_match_a           = legacy_match_byte_a;
      next_match_b           = legacy_match_byte_b;
      next_tx_underrun_flag  = tx_underrun_flag;
      // Reads clear first so a same-cycle event wins below
      // clear on read
      if (rd_rxc) begin
         next_code_seen_latched = 1'b0;
         next_code_change_flag  = 1'b0;
      end
      if (rd_txs) begin
         next_tx_underrun_flag = 1'b0;
      end
      if (legacy_flag_clear) begin
         next_byte_full = 1'b0;
         next_match     = 1'b0;
      end
      if (code_present_now) begin
         next_rx_code           = detected_code;
         next_code_seen_latched = 1'b1;
      end
      if (code_edge) begin
         next_code_change_flag = 1'b1;
      end
      if (wr_txc) begin
         next_send_code_trigger  = host_req.wdata[`DLC_TXC_SEND_BIT];
         next_link_source_select = host_req.wdata[`DLC_TXC_SRC_BIT];
         next_tx_code            = host_req.wdata[5:0];
      end
      if (host_req.wr && host_req.addr == `DLC_ADDR_MATCH_A) begin
         next_match_a = host_req.wdata;
      end
      if (host_req.wr && host_req.addr == `DLC_ADDR_MATCH_B) begin
         next_match_b = host_req.wdata;
      end
      // legacy path runs beside the packet path
      if (legacy_bit_strobe) begin
         if (legacy_bit) begin
            next_ones_run = (ones_run == 3'h7) ? ones_run : ones_run + 3'h1;
         end else begin
            next_ones_run = 3'h0;
         end
         // drop stuffed zero; kept after six ones
         if (!(zero_destuff_enable && !legacy_bit && ones_run == 3'(`DLC_ONES_LIMIT))) begin
            // first bit ends up in LSB
            shifted           = {legacy_bit, legacy_shift[7:1]};
            next_legacy_shift = shifted;
            next_legacy_cnt   = legacy_cnt + 3'h1;
            byte_done         = (legacy_cnt == 3'(`DLC_LEGACY_BITS - 1));
         end
      end
      if (byte_done) begin
         // an unread byte is overwritten here
         next_legacy_rx_byte = shifted;
         next_byte_full      = 1'b1;
         if (shifted == legacy_match_byte_a || shifted == legacy_match_byte_b) begin
            next_match = 1'b1;
         end
      end
      if (tx_state == dlc_pkg::dlc_tx_packet && tx_bit_strobe && tx_bitcnt == 3'h7
          && tx_queue_empty && tx_msg_active) begin
         next_tx_underrun_flag = 1'b1;
      end
   end
   // Host read mux; every field, status included, leaves through the host_rdata register
   always_comb begin
      next_host_rdata = 8'h00;
      if (host_req.addr == `DLC_ADDR_RX_CODE) begin
         next_host_rdata = {code_seen_latched, code_present_now, rx_code};
      end else if (host_req.addr == `DLC_ADDR_RX_FIFO) begin
         next_host_rdata = rxb_valid ? rxb_data : 8'h00;
      end else if (host_req.addr == `DLC_ADDR_TX_STATUS) begin
         next_host_rdata = {5'h00, tx_queue_empty, tx_queue_full, tx_underrun_flag};
      end else if (host_req.addr == `DLC_ADDR_TX_CODE) begin
         next_host_rdata = {send_code_trigger, link_source_select, tx_code};
      end else if (host_req.addr == `DLC_ADDR_LEGACY_RX) begin
         next_host_rdata = legacy_rx_byte;
      end else if (host_req.addr == `DLC_ADDR_MATCH_A) begin
         next_host_rdata = legacy_match_byte_a;
      end else if (host_req.addr == `DLC_ADDR_MATCH_B) begin
         next_host_rdata = legacy_match_byte_b;
      end
   end
   // Transmit sequencer: one internal source at a time
   always_comb begin
      logic send_edge;
      // zero-to-one written to the send bit
      send_edge      = wr_txc && host_req.wdata[`DLC_TXC_SEND_BIT] && !send_code_trigger;
      next_tx_state  = tx_state;
      next_tx_shift  = tx_shift;
      next_tx_bitcnt = tx_bitcnt;
      next_tx_bit    = tx_bit;
      pop            = 1'b0;
      case (tx_state)
         dlc_pkg::dlc_tx_idle: begin
            next_tx_bit = 1'b1;
            if (send_edge) begin
               next_tx_state  = dlc_pkg::dlc_tx_code;
               next_tx_shift  = {2'h0, host_req.wdata[5:0]};
               next_tx_bitcnt = 3'h0;
            end else if (!tx_queue_empty) begin
               next_tx_state  = dlc_pkg::dlc_tx_packet;
               next_tx_shift  = txq[rd_ptr];
               next_tx_bitcnt = 3'h0;
               pop            = 1'b1;
            end
         end
         dlc_pkg::dlc_tx_packet: begin
            if (tx_bit_strobe) begin
               next_tx_bit    = tx_shift[0];
               next_tx_shift  = {1'b0, tx_shift[7:1]};
               next_tx_bitcnt = tx_bitcnt + 3'h1;
               if (tx_bitcnt == 3'h7) begin
                  if (!tx_queue_empty) begin
                     next_tx_shift = txq[rd_ptr];
                     pop           = 1'b1;
                  end else if (tx_msg_active) begin
                     next_tx_shift = 8'hff;
                  end else begin
                     next_tx_state = dlc_pkg::dlc_tx_idle;
                  end
               end
            end
         end
         dlc_pkg::dlc_tx_code: begin
            if (tx_bit_strobe) begin
               next_tx_bit    = tx_shift[0];
               next_tx_shift  = {1'b0, tx_shift[7:1]};
               next_tx_bitcnt = tx_bitcnt + 3'h1;
               if (tx_bitcnt == 3'(`DLC_CODE_BITS - 1)) begin
                  next_tx_state = dlc_pkg::dlc_tx_idle;
               end
            end
         end
         default: next_tx_state = dlc_pkg::dlc_tx_idle;
      endcase
   end
   assign tx_link_bit = link_source_select ? tx_bit : external_link_data_in;
   // byte-full gated by mask; match gated too
   assign int_n = !((legacy_byte_full_flag && legacy_byte_full_mask)
                    || (legacy_match_flag && legacy_match_mask));
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         host_rdata            <= 8'h00;
         rx_code               <= `DLC_CODE_RESET;
         code_seen_latched     <= 1'b0;
         code_prev             <= 1'b0;
         code_change_flag      <= 1'b0;
         send_code_trigger     <= 1'b0;
         link_source_select    <= 1'b0;
         tx_code               <= 6'h00;
         tx_underrun_flag      <= 1'b0;
         legacy_rx_byte        <= `DLC_BYTE_RESET;
         legacy_shift          <= `DLC_BYTE_RESET;
         legacy_cnt            <= 3'h0;
         ones_run              <= 3'h0;
         legacy_byte_full_flag <= 1'b0;
         legacy_match_flag     <= 1'b0;
         legacy_match_byte_a   <= `DLC_BYTE_RESET;
         legacy_match_byte_b   <= `DLC_BYTE_RESET;
         tx_state              <= dlc_pkg::dlc_tx_idle;
         tx_shift              <= 8'h00;
         tx_bitcnt             <= 3'h0;
         tx_bit                <= 1'b1;
         wr_ptr                <= '0;
         rd_ptr                <= '0;
         txq_count             <= '0;
      end else begin
         host_rdata            <= next_host_rdata;
         rx_code               <= next_rx_code;
         code_seen_latched     <= next_code_seen_latched;
         code_prev             <= code_present_now;
         code_change_flag      <= next_code_change_flag;
         send_code_trigger     <= next_send_code_trigger;
         link_source_select    <= next_link_source_select;
         tx_code               <= next_tx_code;
         tx_underrun_flag      <= next_tx_underrun_flag;
         legacy_rx_byte        <= next_legacy_rx_byte;
         legacy_shift          <= next_legacy_shift;
         legacy_cnt            <= next_legacy_cnt;
         ones_run              <= next_ones_run;
         legacy_byte_full_flag <= next_byte_full;
         legacy_match_flag     <= next_match;
         legacy_match_byte_a   <= next_match_a;
         legacy_match_byte_b   <= next_match_b;
         tx_state              <= next_tx_state;
         tx_shift              <= next_tx_shift;
         tx_bitcnt             <= next_tx_bitcnt;
         tx_bit                <= next_tx_bit;
         if (push) begin
            txq[wr_ptr] <= host_req.wdata;
            wr_ptr <= AW'((32'(wr_ptr) + 1) % DEPTH);
         end
         if (pop) begin
            rd_ptr <= AW'((32'(rd_ptr) + 1) % DEPTH);
         end
         txq_count <= txq_count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // dlc_data_link
`default_nettype wire

// ==== hdl/dlc_defs.svh ====
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH
// Register offsets on the parallel port
`define DLC_ADDR_RX_CODE     8'h04
`define DLC_ADDR_RX_FIFO     8'h05
`define DLC_ADDR_TX_STATUS   8'h06
`define DLC_ADDR_TX_CODE     8'h07
`define DLC_ADDR_TX_FIFO     8'h08
`define DLC_ADDR_LEGACY_RX   8'h28
`define DLC_ADDR_MATCH_A     8'h29
`define DLC_ADDR_MATCH_B     8'h2a
// Field positions
`define DLC_RXC_LATCHED_BIT  7
`define DLC_RXC_LIVE_BIT     6
`define DLC_TXC_SEND_BIT     7
`define DLC_TXC_SRC_BIT      6
`define DLC_TXS_EMPTY_BIT    2
`define DLC_TXS_FULL_BIT     1
`define DLC_TXS_UNDER_BIT    0
// Reset values
`define DLC_CODE_RESET       6'h3f
`define DLC_BYTE_RESET       8'h00
// Timing
`define DLC_CODE_BITS        6
`define DLC_LEGACY_BITS      8
`define DLC_ONES_LIMIT       5
`endif

// ==== hdl/dlc_pkg.sv ====
package dlc_pkg;
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dlc_host_req_t;
   typedef enum logic [1:0] {dlc_tx_idle, dlc_tx_packet, dlc_tx_code} dlc_tx_state_t;
endpackage

// ==== hdl/dlc_skid_buffer.sv ====
`timescale 1ns/10ps
`default_nettype none
module dlc_skid_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] slot [0:1];
   logic [WIDTH-1:0] next_slot [0:1];
   logic [1:0]       count;
   logic [1:0]       next_count;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = slot[0];

   always_comb begin
      logic pop;
      logic push;
      pop          = out_valid && out_ready;
      push         = in_valid && in_ready;
      next_slot[0] = slot[0];
      next_slot[1] = slot[1];
      next_count   = count;
      if (pop) begin
         next_slot[0] = slot[1];
      end
      if (push) begin
         if ((count == 2'h0) || (count == 2'h1 && pop)) begin
            next_slot[0] = in_data;
         end else begin
            next_slot[1] = in_data;
         end
      end
      next_count = count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count   <= 2'h0;
         slot[0] <= '0;
         slot[1] <= '0;
      end else begin
         count   <= next_count;
         slot[0] <= next_slot[0];
         slot[1] <= next_slot[1];
      end
   end
endmodule // dlc_skid_buffer
`default_nettype wire

// ==== tb/dlc_data_link_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module dlc_data_link_asserts #(
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   // Host port
   input wire dlc_pkg::dlc_host_req_t host_req,
   input wire logic [7:0]             host_rdata,
   // Flags and masks
   input wire logic                   legacy_byte_full_mask,
   input wire logic                   legacy_match_mask,
   input wire logic                   legacy_byte_full_flag,
   input wire logic                   legacy_match_flag,
   input wire logic                   code_change_flag,
   input wire logic                   legacy_flag_clear,
   input wire logic                   int_n,
   // Streams
   input wire logic                   code_present_now,
   input wire logic                   legacy_bit_strobe,
   input wire logic                   external_link_data_in,
   input wire logic                   tx_link_bit
);
   logic src_int;
   // Mirrors the source select so the pin path can be judged
   always_ff @(posedge sys_clk) begin
      if (!rst_n) src_int <= 1'b0;
      else if (host_req.wr && host_req.addr == 8'h07) src_int <= host_req.wdata[6];
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_INT_FULL: assert property (legacy_byte_full_flag && legacy_byte_full_mask |-> !int_n)
      else $error("int_n high with byte-full enabled");
   AST_INT_MATCH: assert property (legacy_match_flag && legacy_match_mask |-> !int_n)
      else $error("int_n high with match enabled");
   AST_RXC_LIVE: assert property (host_req.rd && host_req.addr == 8'h04
      |=> host_rdata[6] == $past(code_present_now)) else $error("live code bit wrong");
   AST_RXC_SEEN: assert property (code_present_now [*2] ##0
      (host_req.rd && host_req.addr == 8'h04) |=> host_rdata[7]) else $error("seen bit missing");
   AST_TXS_RSVD: assert property (host_req.rd && host_req.addr == 8'h06
      |=> host_rdata[7:3] == 5'h00) else $error("status upper bits set");
   AST_FULL_SET: assert property ($rose(legacy_byte_full_flag) |-> $past(legacy_bit_strobe))
      else $error("byte-full set without a bit");
   AST_MATCH_SET: assert property ($rose(legacy_match_flag) |-> $past(legacy_bit_strobe))
      else $error("match set without a bit");
   AST_CLEAR: assert property (legacy_flag_clear && !legacy_bit_strobe
      |=> !legacy_byte_full_flag && !legacy_match_flag) else $error("flags not cleared");
   AST_STICKY: assert property (legacy_byte_full_flag && !legacy_flag_clear
      |=> legacy_byte_full_flag) else $error("byte-full dropped");
   AST_SRC_PIN: assert property (!src_int |-> tx_link_bit == external_link_data_in)
      else $error("pin source not passed");
   AST_CHANGE: assert property ($changed(code_present_now) |-> ##[1:2] code_change_flag)
      else $error("code change flag missing");
   cover property (host_req.rd && host_req.addr == 8'h04 ##1 host_rdata[7]);
   cover property ($rose(legacy_match_flag));
   cover property ($fell(int_n));
endmodule // dlc_data_link_asserts
bind dlc_data_link dlc_data_link_asserts #(.DEPTH(DEPTH)) u_chk (.sys_clk(sys_clk),
   .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata),
   .legacy_byte_full_mask(legacy_byte_full_mask), .legacy_match_mask(legacy_match_mask),
   .legacy_byte_full_flag(legacy_byte_full_flag), .legacy_match_flag(legacy_match_flag),
   .code_change_flag(code_change_flag), .legacy_flag_clear(legacy_flag_clear),
   .int_n(int_n), .code_present_now(code_present_now),
   .legacy_bit_strobe(legacy_bit_strobe), .external_link_data_in(external_link_data_in),
   .tx_link_bit(tx_link_bit));
`default_nettype wire

// ==== tb/dlc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dlc_host_model (
   // Clock
   input  wire logic                   sys_clk,
   // Parallel port
   output var dlc_pkg::dlc_host_req_t  host_req,
   input  wire logic [7:0]             host_rdata
);
   initial host_req = '0;
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge sys_clk);
      host_req.wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // each read returns within a few cycles
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      host_req.rd <= 1'b0;
      @(negedge sys_clk);
      d = host_rdata;
      @(posedge sys_clk);
   endtask
   // send bit written low first so a rising edge is seen
   task automatic send_code(input logic [5:0] c);
      write(8'h07, {2'b01, c});
      write(8'h07, {2'b11, c});
   endtask
endmodule // dlc_host_model
`default_nettype wire

// ==== tb/test_dlc_data_link.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_dlc_data_link;
   localparam int DEPTH = 4;
   logic sys_clk, rst_n, zero_destuff_enable, legacy_byte_full_mask, legacy_match_mask;
   logic legacy_byte_full_flag, legacy_match_flag, code_change_flag, legacy_flag_clear, int_n;
   logic code_present_now, rx_pkt_valid, rx_pkt_ready, legacy_bit_strobe, legacy_bit;
   logic tx_bit_strobe, external_link_data_in, tx_msg_active, tx_link_bit;
   logic [7:0] host_rdata, rx_pkt_data, rd_val;
   logic [5:0] detected_code;
   dlc_pkg::dlc_host_req_t host_req;
   int fails = 0, num_checks = 0, cycles = 0;
   dlc_data_link #(.DEPTH(DEPTH)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .host_req(host_req), .host_rdata(host_rdata), .zero_destuff_enable(zero_destuff_enable),
      .legacy_byte_full_mask(legacy_byte_full_mask), .legacy_match_mask(legacy_match_mask),
      .legacy_byte_full_flag(legacy_byte_full_flag), .legacy_match_flag(legacy_match_flag),
      .code_change_flag(code_change_flag), .legacy_flag_clear(legacy_flag_clear),
      .int_n(int_n), .code_present_now(code_present_now), .detected_code(detected_code),
      .rx_pkt_valid(rx_pkt_valid), .rx_pkt_data(rx_pkt_data), .rx_pkt_ready(rx_pkt_ready),
      .legacy_bit_strobe(legacy_bit_strobe), .legacy_bit(legacy_bit),
      .tx_bit_strobe(tx_bit_strobe), .external_link_data_in(external_link_data_in),
      .tx_msg_active(tx_msg_active), .tx_link_bit(tx_link_bit));
   dlc_host_model host (.sys_clk(sys_clk), .host_req(host_req), .host_rdata(host_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Runs are a few hundred cycles; a hang stops here
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_byte(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic shift_bits(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         legacy_bit_strobe <= 1'b1;
         legacy_bit <= bits[i];
         @(posedge sys_clk);
         legacy_bit_strobe <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task automatic flag_clear();
      legacy_flag_clear <= 1'b1;
      @(posedge sys_clk);
      legacy_flag_clear <= 1'b0;
      @(negedge sys_clk);
      chk_bit("flags cleared", 1'b0, legacy_byte_full_flag | legacy_match_flag);
      chk_bit("int_n released", 1'b1, int_n);
      @(posedge sys_clk);
   endtask
   task automatic test_reset();
      host.read(8'h04, rd_val);
      chk_byte("rx code after reset", 8'h3f, rd_val);
      host.read(8'h06, rd_val);
      chk_byte("tx status idle", 8'h04, rd_val);
      host.read(8'h33, rd_val);
      chk_byte("unmapped read", 8'h00, rd_val);
      $display("test_reset done");
   endtask
   task automatic test_rx_code();
      code_present_now <= 1'b1;
      detected_code <= 6'h2d;
      repeat (3) @(posedge sys_clk);
      host.read(8'h04, rd_val);
      chk_byte("code seen", 8'hed, rd_val);
      code_present_now <= 1'b0;
      detected_code <= 6'h11;
      repeat (3) @(negedge sys_clk);
      chk_bit("code change", 1'b1, code_change_flag);
      @(posedge sys_clk);
      host.read(8'h04, rd_val);
      chk_byte("code held", 8'had, rd_val);
      chk_bit("change cleared", 1'b0, code_change_flag);
      host.read(8'h04, rd_val);
      chk_byte("seen cleared", 8'h2d, rd_val);
      $display("test_rx_code done");
   endtask
   task automatic test_rx_fifo();
      int n;
      logic ok;
      n = 0;
      ok = 1'b1;
      while (ok && n < 40) begin
         rx_pkt_valid <= 1'b1;
         rx_pkt_data <= 8'h30 + n[7:0];
         @(negedge sys_clk);
         ok = rx_pkt_ready;
         @(posedge sys_clk);
         if (ok) n++;
      end
      rx_pkt_valid <= 1'b0;
      chk_bit("rx stream refused", 1'b1, n < 40);
      for (int i = 0; i < n; i++) begin
         host.read(8'h05, rd_val);
         chk_byte("rx fifo byte", 8'h30 + i[7:0], rd_val);
      end
      host.read(8'h05, rd_val);
      chk_byte("rx fifo empty read", 8'h00, rd_val);
      $display("test_rx_fifo done");
   endtask
   task automatic test_tx_code();
      logic [5:0] seen;
      logic found;
      found = 1'b0;
      seen = 6'h00;
      host.write(8'h07, 8'h00);
      for (int v = 0; v < 2; v++) begin
         external_link_data_in <= v[0];
         @(negedge sys_clk);
         chk_bit("pin source", v[0], tx_link_bit);
         @(posedge sys_clk);
      end
      host.send_code(6'h25);
      tx_bit_strobe <= 1'b1;
      for (int i = 0; i < 60; i++) begin
         @(negedge sys_clk);
         seen = {tx_link_bit, seen[5:1]};
         if (seen == 6'h25) found = 1'b1;
         @(posedge sys_clk);
      end
      tx_bit_strobe <= 1'b0;
      chk_bit("code sent bit 0 first", 1'b1, found);
      $display("test_tx_code done");
   endtask
   task automatic test_tx_fifo();
      int n;
      n = 0;
      do begin
         host.write(8'h08, n[7:0]);
         n++;
         host.read(8'h06, rd_val);
      end while (!rd_val[1] && n < DEPTH + 4);
      chk_bit("tx full reached", 1'b1, rd_val[1]);
      chk_bit("tx full at depth", 1'b1, n >= DEPTH);
      chk_bit("tx not empty", 1'b0, rd_val[2]);
      tx_msg_active <= 1'b1;
      tx_bit_strobe <= 1'b1;
      repeat (200) @(posedge sys_clk);
      tx_bit_strobe <= 1'b0;
      host.read(8'h06, rd_val);
      chk_byte("underrun latched", 8'h05, rd_val);
      tx_msg_active <= 1'b0;
      host.read(8'h06, rd_val);
      chk_byte("underrun cleared", 8'h04, rd_val);
      $display("test_tx_fifo done");
   endtask
   task automatic test_legacy();
      host.write(8'h29, 8'hff);
      host.write(8'h2a, 8'ha5);
      legacy_byte_full_mask <= 1'b1;
      legacy_match_mask <= 1'b1;
      shift_bits(16'h00a5, 8);
      @(negedge sys_clk);
      chk_bit("byte full", 1'b1, legacy_byte_full_flag);
      chk_bit("match", 1'b1, legacy_match_flag);
      chk_bit("int_n low", 1'b0, int_n);
      @(posedge sys_clk);
      host.read(8'h28, rd_val);
      chk_byte("legacy byte", 8'ha5, rd_val);
      flag_clear();
      legacy_byte_full_mask <= 1'b0;
      legacy_match_mask <= 1'b0;
      shift_bits(16'h003c, 8);
      @(negedge sys_clk);
      chk_bit("no match", 1'b0, legacy_match_flag);
      chk_bit("masked int_n", 1'b1, int_n);
      @(posedge sys_clk);
      flag_clear();
      zero_destuff_enable <= 1'b1;
      shift_bits(16'h009f, 9);
      host.read(8'h28, rd_val);
      chk_byte("stuffed zero dropped", 8'h5f, rd_val);
      shift_bits(16'h003f, 8);
      host.read(8'h28, rd_val);
      chk_byte("zero after six kept", 8'h3f, rd_val);
      $display("test_legacy done");
   endtask
   initial begin
      rst_n = 1'b0;
      {zero_destuff_enable, legacy_byte_full_mask, legacy_match_mask, legacy_flag_clear} = '0;
      {code_present_now, rx_pkt_valid, legacy_bit_strobe, legacy_bit} = '0;
      {tx_bit_strobe, external_link_data_in, tx_msg_active} = '0;
      {detected_code, rx_pkt_data} = '0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      test_reset();
      test_rx_code();
      test_rx_fifo();
      test_tx_code();
      test_tx_fifo();
      test_legacy();
      complete_run();
   end
endmodule // test_dlc_data_link
`default_nettype wire
